// >>> include/fsr_regs.vh
`ifndef FSR_REGS_VH
`define FSR_REGS_VH

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define FSR_CMD_WRR 8'h01
`define FSR_CMD_WRITE_ENABLE_CMD 8'h06
`define FSR_CMD_WRITE_DISABLE_CMD 8'h04
`define FSR_CMD_CLEAR_STATUS_CMD 8'h30
`define FSR_CMD_READ_STATUS_FIRST_CMD 8'h05
`define FSR_CMD_READ_STATUS_SECOND_CMD 8'h07
`define FSR_CMD_ERASE_SUSPEND_CMD 8'h75
`define FSR_CMD_PROGRAM_SUSPEND_CMD 8'h85
`define FSR_CMD_SWRST 8'hF0
`define FSR_CMD_PROG 8'h02
`define FSR_CMD_SECT_ERASE 8'hD8
`define FSR_CMD_BULK_ERASE 8'hC7

// ----------------------------------------
// Status byte field positions
// ----------------------------------------
`define FSR_BIT_LOCK 7
`define FSR_BIT_PERR 6
`define FSR_BIT_EERR 5
`define FSR_BP_HI 4
`define FSR_BP_LO 2
`define FSR_BIT_WEL 1
`define FSR_BIT_BUSY 0

// ----------------------------------------
// Reset values and frame lengths in bits
// ----------------------------------------
`define FSR_BP_VOL_RESET 3'h7
`define FSR_BP_CLEAR 3'h0
`define FSR_BITS_CMD 6'h08
`define FSR_BITS_WRR 6'h10
`define FSR_BITS_ERASE 6'h20
`define FSR_BITS_PROG 6'h28
`define FSR_BITS_MAX 6'h3F
`define FSR_IDX_CMD 6'h07
`define FSR_IDX_DATA 6'h0F

// ----------------------------------------
// Array operation kinds
// ----------------------------------------
`define FSR_KIND_PROG 2'h0
`define FSR_KIND_ERASE 2'h1
`define FSR_KIND_BULK 2'h2

`endif

// >>> hw/fsr_status_logic.v
`timescale 1ns/1ps
`include "fsr_regs.vh"

//
// Overview of operation
// - Volatile bits default on every reset kind
// - Lock set and protect low ignores register write
// - Otherwise register write updates lock and protection
// - Program failure or protected target sets program error
// - Erase failure or protected sector sets erase error
// - Whole-array erase never sets erase error on protection
// - Error flags cleared only by hardware reset, clear-status or software-reset command
// - Protection bits volatile or stored per selection
// - Protected areas refuse program and erase
// - Whole-array erase only with protection all zero
// - Write, program, erase need write enable latch
// - Write-enable command sets the latch
// - Write-disable command clears the latch
// - Successful operation completion clears the latch
// - Latch zero after resets, cleared on register write completion
// - While busy only a few commands accepted
// - Suspends accepted only during matching array operation
// - Errors update while busy; busy holds until clear
// - Read-status-first returns the register, even while busy; read-status-second reads zero
// - Busy flag reads zero only when idle
module fsr_status_logic #(
   parameter [15:0] WRR_CYCLES = 16'h0064
) (
   input wire ref_clk,
   input wire rst_n,
   input wire sck,
   input wire cs_n,
   input wire si,
   input wire wp_n,
   output reg so_q,
   output reg so_oe_q,
   input wire protect_volatility_select,
   input wire nv_lock_in,
   input wire [2:0] nv_bp_in,
   input wire op_done,
   input wire op_fail,
   input wire op_prot_hit,
   output reg op_start_q,
   output reg [1:0] op_kind_q,
   output reg op_suspend_q,
   output reg op_abort_q,
   output reg nv_store_q,
   output reg reg_write_lock_q,
   output reg perr_q,
   output reg eerr_q,
   output reg [2:0] bp_q,
   output reg write_enable_latch_q,
   output reg busy_flag_q
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_WRR = 2'h1;
   localparam [1:0] ST_ARRAY = 2'h2;
   localparam [1:0] ST_ERR = 2'h3;

   // ----------------------------------------
   // Commands honoured while busy
   // ----------------------------------------
   function busy_ok;
      input [7:0] c;
      begin
         busy_ok = (c == `FSR_CMD_READ_STATUS_FIRST_CMD) || (c == `FSR_CMD_READ_STATUS_SECOND_CMD) ||
                   (c == `FSR_CMD_ERASE_SUSPEND_CMD) || (c == `FSR_CMD_PROGRAM_SUSPEND_CMD) ||
                   (c == `FSR_CMD_CLEAR_STATUS_CMD) || (c == `FSR_CMD_SWRST);
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg sck_m, sck_s, sck_p;
   reg cs_m, cs_s, cs_p;
   reg si_m, si_s;
   reg wp_m, wp_s;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_p <= 1'b0;
         cs_m <= 1'b1;
         cs_s <= 1'b1;
         cs_p <= 1'b1;
         si_m <= 1'b0;
         si_s <= 1'b0;
         wp_m <= 1'b0;
         wp_s <= 1'b0;
      end else begin
         sck_m <= sck;
         sck_s <= sck_m;
         sck_p <= sck_s;
         cs_m <= cs_n;
         cs_s <= cs_m;
         cs_p <= cs_s;
         si_m <= si;
         si_s <= si_m;
         wp_m <= wp_n;
         wp_s <= wp_m;
      end
   end

   wire sck_rise = sck_s & ~sck_p;
   wire sck_fall = ~sck_s & sck_p;
   wire cs_act = ~cs_s;
   wire cs_end = cs_s & ~cs_p;

   // ----------------------------------------
   // Serial frame capture
   // ----------------------------------------
   reg [5:0] bit_cnt_q;
   reg [7:0] sh_q;
   reg [7:0] cmd_q;
   reg [7:0] data_q;
   wire [7:0] sh_next = {sh_q[6:0], si_s};

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q <= 6'h00;
         sh_q <= 8'h00;
         cmd_q <= 8'h00;
         data_q <= 8'h00;
      end else if (!cs_act) begin
         // Count survives the first idle cycle so cs_end sees it
         if (!cs_end) begin
            bit_cnt_q <= 6'h00;
         end
      end else if (sck_rise) begin
         sh_q <= sh_next;
         if (bit_cnt_q != `FSR_BITS_MAX) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
         if (bit_cnt_q == `FSR_IDX_CMD) begin
            cmd_q <= sh_next;
         end
         if (bit_cnt_q == `FSR_IDX_DATA) begin
            data_q <= sh_next;
         end
      end
   end

   // ----------------------------------------
   // Status read-out on falling clock
   // ----------------------------------------
   wire [7:0] status = {reg_write_lock_q, perr_q, eerr_q, bp_q,
                        write_enable_latch_q, busy_flag_q};
   wire rd_cmd = (cmd_q == `FSR_CMD_READ_STATUS_FIRST_CMD) || (cmd_q == `FSR_CMD_READ_STATUS_SECOND_CMD);
   wire rd_act = cs_act && rd_cmd && (bit_cnt_q >= `FSR_BITS_CMD);
   // Second status register is not modelled; it reads as zero
   wire [7:0] rd_val = (cmd_q == `FSR_CMD_READ_STATUS_FIRST_CMD) ? status : 8'h00;
   reg [2:0] tx_cnt_q;
   reg [7:0] tx_q;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt_q <= 3'h0;
         tx_q <= 8'h00;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         so_oe_q <= rd_act;
         if (!rd_act) begin
            tx_cnt_q <= 3'h0;
         end else if (sck_fall) begin
            tx_cnt_q <= tx_cnt_q + 3'h1;
            // Reload each byte so repeated reads track live status
            if (tx_cnt_q == 3'h0) begin
               so_q <= rd_val[7];
               tx_q <= {rd_val[6:0], 1'b0};
            end else begin
               so_q <= tx_q[7];
               tx_q <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------
   // Command execution and status state
   // ----------------------------------------
   reg [1:0] st_q;
   reg [15:0] wrr_cnt_q;
   reg [7:0] wrr_val_q;
   reg load_q;

   wire allowed = ~busy_flag_q | busy_ok(cmd_q);
   wire go = cs_end & allowed;
   wire hw_locked = reg_write_lock_q & ~wp_s;
   wire is_erase = (op_kind_q != `FSR_KIND_PROG);
   wire op_bad = op_fail | (op_prot_hit & (op_kind_q != `FSR_KIND_BULK));

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         wrr_cnt_q <= 16'h0000;
         wrr_val_q <= 8'h00;
         load_q <= 1'b1;
         op_start_q <= 1'b0;
         op_kind_q <= `FSR_KIND_PROG;
         op_suspend_q <= 1'b0;
         op_abort_q <= 1'b0;
         nv_store_q <= 1'b0;
         reg_write_lock_q <= 1'b0;
         perr_q <= 1'b0;
         eerr_q <= 1'b0;
         bp_q <= `FSR_BP_VOL_RESET;
         write_enable_latch_q <= 1'b0;
         busy_flag_q <= 1'b0;
      end else begin
         op_start_q <= 1'b0;
         op_suspend_q <= 1'b0;
         op_abort_q <= 1'b0;
         nv_store_q <= 1'b0;
         // Stored bits are fetched once after reset release
         if (load_q) begin
            load_q <= 1'b0;
            reg_write_lock_q <= nv_lock_in;
            bp_q <= protect_volatility_select ? `FSR_BP_VOL_RESET
                                              : nv_bp_in;
         end
         if (go) begin
            case (cmd_q)
               `FSR_CMD_WRITE_ENABLE_CMD: begin
                  if (bit_cnt_q == `FSR_BITS_CMD) begin
                     write_enable_latch_q <= 1'b1;
                  end
               end
               `FSR_CMD_WRITE_DISABLE_CMD: begin
                  if (bit_cnt_q == `FSR_BITS_CMD) begin
                     write_enable_latch_q <= 1'b0;
                  end
               end
               `FSR_CMD_CLEAR_STATUS_CMD: begin
                  if (bit_cnt_q == `FSR_BITS_CMD) begin
                     perr_q <= 1'b0;
                     eerr_q <= 1'b0;
                     if (st_q == ST_ERR) begin
                        st_q <= ST_IDLE;
                        busy_flag_q <= 1'b0;
                     end
                  end
               end
               `FSR_CMD_SWRST: begin
                  if (bit_cnt_q == `FSR_BITS_CMD) begin
                     perr_q <= 1'b0;
                     eerr_q <= 1'b0;
                     write_enable_latch_q <= 1'b0;
                     busy_flag_q <= 1'b0;
                     st_q <= ST_IDLE;
                     op_abort_q <= (st_q == ST_ARRAY);
                     if (protect_volatility_select) begin
                        bp_q <= `FSR_BP_VOL_RESET;
                     end
                  end
               end
               `FSR_CMD_WRR: begin
                  // Silently dropped when locked by the protect pin
                  if ((bit_cnt_q >= `FSR_BITS_WRR) && write_enable_latch_q &&
                      !hw_locked) begin
                     wrr_val_q <= data_q;
                     wrr_cnt_q <= WRR_CYCLES;
                     st_q <= ST_WRR;
                     busy_flag_q <= 1'b1;
                  end
               end
               `FSR_CMD_PROG: begin
                  if ((bit_cnt_q >= `FSR_BITS_PROG) && write_enable_latch_q) begin
                     op_kind_q <= `FSR_KIND_PROG;
                     op_start_q <= 1'b1;
                     st_q <= ST_ARRAY;
                     busy_flag_q <= 1'b1;
                  end
               end
               `FSR_CMD_SECT_ERASE: begin
                  if ((bit_cnt_q == `FSR_BITS_ERASE) && write_enable_latch_q) begin
                     op_kind_q <= `FSR_KIND_ERASE;
                     op_start_q <= 1'b1;
                     st_q <= ST_ARRAY;
                     busy_flag_q <= 1'b1;
                  end
               end
               `FSR_CMD_BULK_ERASE: begin
                  if ((bit_cnt_q == `FSR_BITS_CMD) && write_enable_latch_q &&
                      (bp_q == `FSR_BP_CLEAR)) begin
                     op_kind_q <= `FSR_KIND_BULK;
                     op_start_q <= 1'b1;
                     st_q <= ST_ARRAY;
                     busy_flag_q <= 1'b1;
                  end
               end
               `FSR_CMD_ERASE_SUSPEND_CMD: begin
                  op_suspend_q <= (st_q == ST_ARRAY) && is_erase;
               end
               `FSR_CMD_PROGRAM_SUSPEND_CMD: begin
                  op_suspend_q <= (st_q == ST_ARRAY) && !is_erase;
               end
               default: begin
               end
            endcase
         end
         // Completion handled after commands so a new error beats a clear
         if (st_q == ST_WRR && !(go && cmd_q == `FSR_CMD_SWRST)) begin
            if (wrr_cnt_q != 16'h0000) begin
               wrr_cnt_q <= wrr_cnt_q - 16'h0001;
            end else begin
               reg_write_lock_q <= wrr_val_q[`FSR_BIT_LOCK];
               bp_q <= wrr_val_q[`FSR_BP_HI:`FSR_BP_LO];
               nv_store_q <= 1'b1;
               write_enable_latch_q <= 1'b0;
               busy_flag_q <= 1'b0;
               st_q <= ST_IDLE;
            end
         end
         if (st_q == ST_ARRAY && op_done && !(go && cmd_q == `FSR_CMD_SWRST)) begin
            if (op_bad) begin
               // Busy held until cleared; latch left for host to drop
               perr_q <= perr_q | !is_erase;
               eerr_q <= eerr_q | is_erase;
               st_q <= ST_ERR;
            end else begin
               write_enable_latch_q <= 1'b0;
               busy_flag_q <= 1'b0;
               st_q <= ST_IDLE;
            end
         end
      end
   end

endmodule

// >>> verif/fsr_status_monitor.sv
`timescale 1ns/1ps
`include "fsr_regs.vh"
module fsr_status_monitor #(
   parameter [15:0] WRR_CYCLES = 16'h0064
) (
   input wire ref_clk,
   input wire rst_n,
   input wire op_done,
   input wire op_fail,
   input wire op_prot_hit,
   input wire op_start_q,
   input wire [1:0] op_kind_q,
   input wire [2:0] bp_q,
   input wire perr_q,
   input wire eerr_q,
   input wire write_enable_latch_q,
   input wire busy_flag_q
);
   // ----------------
   // Status checks
   // ----------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_reset_defaults: assert property ($rose(rst_n) |-> bp_q == 3'h7 && !perr_q && !eerr_q
      && !write_enable_latch_q && !busy_flag_q) else $error("reset value wrong");
   a_busy_holds_err: assert property (perr_q || eerr_q |-> busy_flag_q)
      else $error("error without busy");
   a_start_needs_wel: assert property (op_start_q |-> write_enable_latch_q ##1 busy_flag_q)
      else $error("start without latch");
   a_bulk_bp_clear: assert property (op_start_q && op_kind_q == `FSR_KIND_BULK |-> bp_q == 3'h0)
      else $error("bulk erase while protected");
   a_prog_err_set: assert property (op_done && busy_flag_q && op_kind_q == `FSR_KIND_PROG
      && (op_fail || op_prot_hit) |=> perr_q) else $error("program error lost");
   a_erase_err_set: assert property (op_done && busy_flag_q && op_kind_q == `FSR_KIND_ERASE
      && (op_fail || op_prot_hit) |=> eerr_q) else $error("erase error lost");
   a_done_clears_wel: assert property (op_done && busy_flag_q && !op_fail && !perr_q && !eerr_q
      && (!op_prot_hit || op_kind_q == `FSR_KIND_BULK) |=> !write_enable_latch_q && !busy_flag_q
      && !eerr_q) else $error("completion not clean");
   a_err_needs_done: assert property ($rose(perr_q) || $rose(eerr_q) |-> $past(op_done))
      else $error("error flag without cause");
endmodule
bind fsr_status_logic fsr_status_monitor #(.WRR_CYCLES(WRR_CYCLES)) fsr_status_monitor_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .op_done(op_done), .op_fail(op_fail),
   .op_prot_hit(op_prot_hit), .op_start_q(op_start_q), .op_kind_q(op_kind_q), .bp_q(bp_q),
   .perr_q(perr_q), .eerr_q(eerr_q), .write_enable_latch_q(write_enable_latch_q),
   .busy_flag_q(busy_flag_q));

// >>> verif/fsr_host_model.sv
`timescale 1ns/1ps
module fsr_host_model (
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire so
);
   // ----------------
   // Serial host
   // ----------------
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b1;
   end
   // Mode 0, MSB first; clock stands low outside frames
   task automatic xfer(input logic [47:0] bits, input int n, output logic [7:0] rd);
      cs_n = 1'b0;
      #62.5;
      for (int i = n - 1; i >= 0; i--) begin
         si = bits[i];
         #62.5;
         sck = 1'b1;
         rd = {rd[6:0], so};
         #62.5;
         sck = 1'b0;
      end
      // Released line must not keep a stale level
      si = ~si;
      #62.5;
      cs_n = 1'b1;
      #100;
   endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "fsr_regs.vh"
module testbench;
   logic ref_clk, rst_n, wp_n, op_done, op_fail, op_prot_hit;
   wire sck, cs_n, si, so_q, start, susp_q, lock_q, perr_q, eerr_q, wel_q, busy_q;
   wire oe_q, abort_q, store_q;
   int oe_cnt = 0, aborts = 0, stores = 0;
   wire [1:0] kind_q;
   wire [2:0] bp_q;
   wire [7:0] st = {lock_q, perr_q, eerr_q, bp_q, wel_q, busy_q};
   int error_cnt = 0, checked = 0, cyc = 0, starts = 0, susp = 0, n0;
   logic [1:0] kind;
   logic [7:0] rd;
   fsr_status_logic #(.WRR_CYCLES(16'h0004)) fsr_status_logic_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
      .so_q(so_q), .so_oe_q(oe_q), .protect_volatility_select(1'b1), .nv_lock_in(1'b0),
      .nv_bp_in(3'h0), .op_done(op_done), .op_fail(op_fail), .op_prot_hit(op_prot_hit),
      .op_start_q(start), .op_kind_q(kind_q), .op_suspend_q(susp_q), .op_abort_q(abort_q),
      .nv_store_q(store_q), .reg_write_lock_q(lock_q), .perr_q(perr_q), .eerr_q(eerr_q),
      .bp_q(bp_q),
      .write_enable_latch_q(wel_q), .busy_flag_q(busy_q));
   fsr_host_model fsr_host_model_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so_q));
   // ----------------
   // Helpers
   // ----------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (start) begin
         starts++;
         kind = kind_q;
      end
      if (susp_q) susp++;
      if (oe_q) oe_cnt++;
      if (abort_q) aborts++;
      if (store_q) stores++;
      if (cyc == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(input logic [47:0] b, input int n);
      fsr_host_model_inst.xfer(b, n, rd);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic done(input logic f, input logic p);
      tick(1);
      {op_done, op_fail, op_prot_hit} = {1'b1, f, p};
      tick(1);
      op_done = 1'b0;
      tick(1);
   endtask
   task automatic write_registers_cmd(input logic [7:0] d);
      cmd({`FSR_CMD_WRR, d}, 16);
      for (int i = 0; i < 50 && busy_q !== 1'b0; i++) tick(1);
   endtask
   task automatic tally_and_finish();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_latch();
      chk("reset", st, 8'h1C);
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      chk("oe idle", oe_cnt[7:0], 8'h00);
      cmd({`FSR_CMD_READ_STATUS_FIRST_CMD, 8'h00}, 16);
      chk("read", rd, 8'h1E);
      chk("oe read", {7'h00, oe_cnt > 0}, 8'h01);
      cmd(`FSR_CMD_WRITE_DISABLE_CMD, 8);
      chk("write_disable_cmd", st, 8'h1C);
   endtask
   task automatic t_wrr();
      write_registers_cmd(8'h00);
      chk("no wel", st, 8'h1C);
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      write_registers_cmd(8'hE2);
      chk("wrr", st, 8'h80);
      wp_n = 1'b0;
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      write_registers_cmd(8'h1C);
      chk("locked", st, 8'h82);
      wp_n = 1'b1;
      write_registers_cmd(8'h00);
      chk("unlock", st, 8'h00);
      chk("stores", stores[7:0], 8'h02);
   endtask
   task automatic t_prog();
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      cmd({`FSR_CMD_PROG, 32'h0000_0000}, 40);
      chk("kind", {6'h00, kind}, {6'h00, `FSR_KIND_PROG});
      cmd(`FSR_CMD_WRITE_DISABLE_CMD, 8);
      chk("busy", st, 8'h03);
      cmd(`FSR_CMD_PROGRAM_SUSPEND_CMD, 8);
      cmd(`FSR_CMD_ERASE_SUSPEND_CMD, 8);
      chk("susp", susp[7:0], 8'h01);
      done(1'b1, 1'b0);
      cmd({`FSR_CMD_READ_STATUS_FIRST_CMD, 8'h00}, 16);
      chk("perr", rd, 8'h43);
      cmd(`FSR_CMD_CLEAR_STATUS_CMD, 8);
      chk("clear_status_cmd", st, 8'h02);
      cmd(`FSR_CMD_WRITE_DISABLE_CMD, 8);
      chk("write_disable_cmd", st, 8'h00);
   endtask
   task automatic t_erase();
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      cmd({`FSR_CMD_SECT_ERASE, 24'h00_0000}, 32);
      chk("kind", {6'h00, kind}, {6'h00, `FSR_KIND_ERASE});
      done(1'b0, 1'b1);
      chk("eerr", st, 8'h23);
      cmd(`FSR_CMD_CLEAR_STATUS_CMD, 8);
      cmd(`FSR_CMD_WRITE_DISABLE_CMD, 8);
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      cmd(`FSR_CMD_BULK_ERASE, 8);
      chk("kind", {6'h00, kind}, {6'h00, `FSR_KIND_BULK});
      done(1'b0, 1'b1);
      chk("bulk", st, 8'h00);
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      write_registers_cmd(8'h04);
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      n0 = starts;
      cmd(`FSR_CMD_BULK_ERASE, 8);
      chk("refused", 8'(starts - n0), 8'h00);
      chk("kept", st, 8'h06);
      cmd(`FSR_CMD_SWRST, 8);
      chk("swrst", st, 8'h1C);
      cmd(`FSR_CMD_WRITE_ENABLE_CMD, 8);
      cmd({`FSR_CMD_PROG, 32'h0000_0000}, 40);
      cmd(`FSR_CMD_SWRST, 8);
      chk("abort", aborts[7:0], 8'h01);
      chk("abort st", st, 8'h1C);
   endtask
   initial begin
      {rst_n, wp_n, op_done, op_fail, op_prot_hit} = 5'b01000;
      tick(2);
      rst_n = 1'b1;
      tick(2);
      t_latch();
      t_wrr();
      t_prog();
      t_erase();
      tally_and_finish();
   end
endmodule
